// ---- include/bst_pkg.sv ----
// Constants, opcodes and types of the boundary-scan test port.
// Assumes a 10-bit instruction register.
package bst_pkg;

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   localparam int         IR_W        = 10;
   localparam logic [9:0] IR_CAPT     = 10'h001;
   localparam logic [9:0] OP_EXTEST   = 10'h000;
   localparam logic [9:0] OP_CFG_LOAD = 10'h002;
   localparam logic [9:0] OP_SAMPLE   = 10'h005;
   localparam logic [9:0] OP_DEVICE_IDENTITY_REGISTER   = 10'h006;
   localparam logic [9:0] OP_USER_SIGNATURE_REGISTER = 10'h007;
   localparam logic [9:0] OP_BYPASS   = 10'h3FF;

   // ----------------------------------------
   // Chain lengths per variant
   // ----------------------------------------
   localparam int BSR_LEN_V0 = 690;
   localparam int BSR_LEN_V1 = 798;
   localparam int BSR_LEN_V2 = 1050;
   localparam int BSR_LEN_V3 = 1308;
   localparam int BSR_LEN_V4 = 1446;

   // ----------------------------------------
   // Identity and signature layout
   // ----------------------------------------
   localparam int   DR_W       = 32;
   localparam int   ID_VER_W   = 4;
   localparam int   ID_PART_W  = 16;
   localparam int   ID_MFR_W   = 11;
   localparam logic ID_LSB     = 1'b1;
   localparam int   USER_OWN_W = 7;
   localparam int   USER_FIX_W = 25;

   // ----------------------------------------
   // Configuration stream
   // ----------------------------------------
   localparam int         CFG_W      = 8;
   localparam int         FIFO_DEPTH = 16;
   localparam logic [2:0] CFG_LAST   = 3'h7;

   typedef enum logic [3:0] {
      ST_RESET  = 4'h0, ST_IDLE   = 4'h1, ST_SEL_DR = 4'h3,
      ST_CAP_DR = 4'h2, ST_SH_DR  = 4'h6, ST_EX1_DR = 4'h7,
      ST_PAU_DR = 4'h5, ST_EX2_DR = 4'h4, ST_UPD_DR = 4'hC,
      ST_SEL_IR = 4'hD, ST_CAP_IR = 4'hF, ST_SH_IR  = 4'hE,
      ST_EX1_IR = 4'hA, ST_PAU_IR = 4'hB, ST_EX2_IR = 4'h9,
      ST_UPD_IR = 4'h8
   } bst_tap_t;

   typedef enum logic [2:0] {
      SEL_BYP = 3'h0, SEL_BSR = 3'h1, SEL_ID = 3'h3,
      SEL_USER = 3'h2, SEL_CFG = 3'h6
   } bst_sel_t;

endpackage

// ---- include/bst_fifo_if.sv ----
// Valid/ready carrier between the port core and its stream buffer.
// Assumes both sides sit on one clock.
`timescale 1ns/1ps
interface bst_fifo_if #(parameter int W = 8);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport fifo (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data);
endinterface

// ---- design/bst_fifo.sv ----
// Synchronous stream buffer, parameter width and depth.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module bst_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   bst_fifo_if.fifo bus
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE  = (AW+1)'(1);

   if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_chk
      $error("bst_fifo depth must be a power of two");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } bst_fifo_st_t;

   bst_fifo_st_t s;
   bst_fifo_st_t next_s;
   logic         push;
   logic         pop;

   // ----------------------------------------
   // Flags straight from the count
   // ----------------------------------------
   assign bus.in_ready  = s.cnt != FULL;
   assign bus.out_valid = s.cnt != '0;
   assign bus.out_data  = s.mem[s.rp];

   always_comb begin
      push   = bus.in_valid && bus.in_ready;
      pop    = bus.out_valid && bus.out_ready;
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = bus.in_data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + ONE;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - ONE;
      end
      if (!rst_n) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   chk_fifo_full:
   assert property (@(posedge clk) disable iff (!rst_n)
      s.cnt == FULL |-> !bus.in_ready ##1 (s.cnt == FULL || $past(pop)))
      else $error("fifo accepted while full");

endmodule // bst_fifo

// ---- design/bst_tap.sv ----
// Boundary-scan test access port with identity, signature and a
// configuration stream. Assumes TCK is free of REF_CLK in phase and
// keeps running for a few edges while NRST is low.
`timescale 1ns/1ps
module bst_tap #(
   parameter int          BSR_LEN    = bst_pkg::BSR_LEN_V2,
   parameter logic [3:0]  ID_VERSION = 4'h3,        // Arbitrary value
   parameter logic [15:0] ID_PART    = 16'h5A3C,    // Arbitrary value
   parameter logic [10:0] ID_MFR     = 11'h2B5,     // Arbitrary value
   parameter logic [24:0] USER_FIXED = 25'h0123456  // Arbitrary value
) (
   input  wire logic               REF_CLK,
   input  wire logic               NRST,
   input  wire logic               TCK,
   input  wire logic               TMS,
   input  wire logic               TDI,
   output logic                    TDO,
   output logic                    TDO_OE,
   input  wire logic [BSR_LEN-1:0] PIN_IN,
   input  wire logic [BSR_LEN-1:0] CORE_OUT,
   output logic      [BSR_LEN-1:0] PIN_OUT,
   input  wire logic [6:0]         USER_SIG,
   output logic                    CONFIGURING,
   output logic      [7:0]         CFG_DATA,
   output logic                    CFG_VALID,
   input  wire logic               CFG_READY
);
   localparam logic [31:0] ID_WORD =
      {ID_VERSION, ID_PART, ID_MFR, bst_pkg::ID_LSB};

   if (BSR_LEN < 2 || bst_pkg::USER_OWN_W + bst_pkg::USER_FIX_W
       != bst_pkg::DR_W) begin : g_chk
      $error("bst_tap chain or signature width not served");
   end

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic bst_pkg::bst_tap_t tap_next(
      input bst_pkg::bst_tap_t s,
      input logic              m);
      bst_pkg::bst_tap_t n;
      n = s;
      unique case (s)
         bst_pkg::ST_RESET:  n = m ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:   n = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: n = m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: n = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR:  n = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR: n = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_PAU_DR: n = m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_EX2_DR: n = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR: n = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: n = m ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: n = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR:  n = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR: n = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_PAU_IR: n = m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_EX2_IR: n = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR: n = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      endcase
      return n;
   endfunction

   function automatic bst_pkg::bst_sel_t dr_sel(input logic [9:0] op);
      bst_pkg::bst_sel_t v;
      unique case (op)
         bst_pkg::OP_EXTEST:   v = bst_pkg::SEL_BSR;
         bst_pkg::OP_SAMPLE:   v = bst_pkg::SEL_BSR;
         bst_pkg::OP_DEVICE_IDENTITY_REGISTER:   v = bst_pkg::SEL_ID;
         bst_pkg::OP_USER_SIGNATURE_REGISTER: v = bst_pkg::SEL_USER;
         bst_pkg::OP_CFG_LOAD: v = bst_pkg::SEL_CFG;
         default:              v = bst_pkg::SEL_BYP;
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // State of the three clock regions
   // ----------------------------------------
   typedef struct packed {
      logic                rs1;
      logic                rs2;
      logic [BSR_LEN-1:0]  pin1;
      logic [BSR_LEN-1:0]  pin2;
      logic [6:0]          us1;
      logic [6:0]          us2;
      logic                ak1;
      logic                ak2;
      bst_pkg::bst_tap_t   st;
      logic [9:0]          ir_sh;
      logic [9:0]          ir;
      logic                ext_on;
      logic                cfg_on;
      logic                byp;
      logic [31:0]         dr32;
      logic [BSR_LEN-1:0]  bsr_sh;
      logic [BSR_LEN-1:0]  bsr_upd;
      logic                utog;
      logic [7:0]          cfg_sh;
      logic [7:0]          cfg_byte;
      logic [2:0]          cfg_cnt;
      logic                ctog;
   } bst_tck_t;

   typedef struct packed {
      logic tdo;
      logic oe;
   } bst_neg_t;

   typedef struct packed {
      logic                e1;
      logic                e2;
      logic                c1;
      logic                c2;
      logic                u1;
      logic                u2;
      logic                u3;
      logic                g1;
      logic                g2;
      logic                g3;
      logic [BSR_LEN-1:0]  img;
      logic [BSR_LEN-1:0]  pout;
      logic                pend;
      logic [7:0]          pdata;
      logic                ack;
      logic                cfgo;
      logic [7:0]          odata;
      logic                ovalid;
   } bst_ref_t;

   bst_tck_t          t;
   bst_tck_t          next_t;
   bst_neg_t          n;
   bst_neg_t          next_n;
   bst_ref_t          r;
   bst_ref_t          next_r;
   bst_pkg::bst_sel_t sel;
   logic              tdo_bit;
   logic              in_shift;

   bst_fifo_if #(.W(bst_pkg::CFG_W)) fbus ();

   // ----------------------------------------
   // Test clock region
   // ----------------------------------------
   always_comb begin
      sel      = dr_sel(t.ir);
      next_t   = t;
      next_t.rs1  = NRST;
      next_t.rs2  = t.rs1;
      next_t.pin1 = PIN_IN;
      next_t.pin2 = t.pin1;
      next_t.us1  = USER_SIG;
      next_t.us2  = t.us1;
      next_t.ak1  = r.ack;
      next_t.ak2  = t.ak1;
      next_t.st   = tap_next(t.st, TMS);
      if (t.st == bst_pkg::ST_RESET) begin
         next_t.ir = bst_pkg::OP_DEVICE_IDENTITY_REGISTER;
      end else if (t.st == bst_pkg::ST_CAP_IR) begin
         next_t.ir_sh = bst_pkg::IR_CAPT;
      end else if (t.st == bst_pkg::ST_SH_IR) begin
         next_t.ir_sh = {TDI, t.ir_sh[9:1]};
      end else if (t.st == bst_pkg::ST_UPD_IR) begin
         next_t.ir = t.ir_sh;
      end else if (t.st == bst_pkg::ST_CAP_DR) begin
         next_t.byp     = 1'b0;
         next_t.cfg_cnt = '0;
         if (sel == bst_pkg::SEL_BSR) begin
            next_t.bsr_sh = t.pin2;
         end else if (sel == bst_pkg::SEL_ID) begin
            next_t.dr32 = ID_WORD;
         end else if (sel == bst_pkg::SEL_USER) begin
            next_t.dr32 = {USER_FIXED, t.us2};
         end
      end else if (t.st == bst_pkg::ST_SH_DR) begin
         next_t.byp    = TDI;
         next_t.dr32   = {TDI, t.dr32[31:1]};
         next_t.bsr_sh = {TDI, t.bsr_sh[BSR_LEN-1:1]};
         if (sel == bst_pkg::SEL_CFG) begin
            next_t.cfg_sh  = {TDI, t.cfg_sh[7:1]};
            next_t.cfg_cnt = t.cfg_cnt + 1'b1;
            // Byte lost if the previous one was not yet taken
            if (t.cfg_cnt == bst_pkg::CFG_LAST && t.ak2 == t.ctog) begin
               next_t.cfg_byte = {TDI, t.cfg_sh[7:1]};
               next_t.ctog     = ~t.ctog;
            end
         end
      end else if (t.st == bst_pkg::ST_UPD_DR) begin
         if (sel == bst_pkg::SEL_BSR) begin
            next_t.bsr_upd = t.bsr_sh;
            next_t.utog    = ~t.utog;
         end
      end
      next_t.ext_on = next_t.ir == bst_pkg::OP_EXTEST;
      next_t.cfg_on = next_t.ir == bst_pkg::OP_CFG_LOAD;
      if (!t.rs2) begin
         next_t.st      = bst_pkg::ST_RESET;
         next_t.ir      = bst_pkg::OP_DEVICE_IDENTITY_REGISTER;
         next_t.ext_on  = 1'b0;
         next_t.cfg_on  = 1'b0;
         next_t.byp     = 1'b0;
         next_t.bsr_upd = '0;
         next_t.utog    = 1'b0;
         next_t.cfg_cnt = '0;
         next_t.ctog    = 1'b0;
      end
   end

   always_ff @(posedge TCK) begin
      t <= next_t;
   end

   // ----------------------------------------
   // Falling edge output stage
   // ----------------------------------------
   always_comb begin
      in_shift = t.st == bst_pkg::ST_SH_IR || t.st == bst_pkg::ST_SH_DR;
      tdo_bit  = t.byp;
      if (t.st == bst_pkg::ST_SH_IR) begin
         tdo_bit = t.ir_sh[0];
      end else if (sel == bst_pkg::SEL_BSR) begin
         tdo_bit = t.bsr_sh[0];
      end else if (sel == bst_pkg::SEL_ID || sel == bst_pkg::SEL_USER) begin
         tdo_bit = t.dr32[0];
      end else if (sel == bst_pkg::SEL_CFG) begin
         tdo_bit = t.cfg_sh[0];
      end
      next_n.oe  = in_shift && t.rs2;
      next_n.tdo = in_shift && t.rs2 && tdo_bit;
   end

   always_ff @(negedge TCK) begin
      n <= next_n;
   end

   assign TDO    = n.tdo;
   assign TDO_OE = n.oe;

   // ----------------------------------------
   // Reference clock region
   // ----------------------------------------
   assign fbus.in_valid  = r.pend;
   assign fbus.in_data   = r.pdata;
   assign fbus.out_ready = !r.ovalid || CFG_READY;

   always_comb begin
      next_r    = r;
      next_r.e1 = t.ext_on;
      next_r.e2 = r.e1;
      next_r.c1 = t.cfg_on;
      next_r.c2 = r.c1;
      next_r.u1 = t.utog;
      next_r.u2 = r.u1;
      next_r.u3 = r.u2;
      next_r.g1 = t.ctog;
      next_r.g2 = r.g1;
      next_r.g3 = r.g2;
      next_r.cfgo = r.c2;
      // Update image is steady for a few edges after its toggle
      if (r.u2 != r.u3) begin
         next_r.img = t.bsr_upd;
      end
      // Pins stay with the core while configuring
      if (r.e2 && !r.c2) begin
         next_r.pout = r.img;
      end else begin
         next_r.pout = CORE_OUT;
      end
      if (r.g2 != r.g3) begin
         next_r.pend  = 1'b1;
         next_r.pdata = t.cfg_byte;
      end else if (r.pend && fbus.in_ready) begin
         next_r.pend = 1'b0;
         next_r.ack  = ~r.ack;
      end
      if (fbus.out_valid && fbus.out_ready) begin
         next_r.odata  = fbus.out_data;
         next_r.ovalid = 1'b1;
      end else if (CFG_READY) begin
         next_r.ovalid = 1'b0;
      end
      if (!NRST) begin
         next_r = '0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      r <= next_r;
   end

   bst_fifo #(
      .W     (bst_pkg::CFG_W),
      .DEPTH (bst_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk   (REF_CLK),
      .rst_n (NRST),
      .bus   (fbus.fifo)
   );

   assign PIN_OUT     = r.pout;
   assign CONFIGURING = r.cfgo;
   assign CFG_DATA    = r.odata;
   assign CFG_VALID   = r.ovalid;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_bypass_path:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      t.st == bst_pkg::ST_SH_DR && sel == bst_pkg::SEL_BYP
      |=> t.byp == $past(TDI))
      else $error("bypass bit did not take TDI");

   chk_chain_capture:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      t.st == bst_pkg::ST_CAP_DR && sel == bst_pkg::SEL_BSR
      |=> t.bsr_sh == $past(t.pin2))
      else $error("chain missed pin capture");

   chk_extest_drive:
   assert property (@(posedge REF_CLK) disable iff (!NRST)
      r.e2 && !r.c2 |=> PIN_OUT == $past(r.img))
      else $error("pins not driven from chain");

   chk_user_load:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      t.st == bst_pkg::ST_CAP_DR && sel == bst_pkg::SEL_USER
      |=> t.dr32[31:7] == USER_FIXED && t.dr32[6:0] == $past(t.us2))
      else $error("signature load wrong");

   chk_ident_load:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      t.st == bst_pkg::ST_CAP_DR && sel == bst_pkg::SEL_ID
      |=> t.dr32 == ID_WORD && t.dr32[0])
      else $error("identity load wrong");

   chk_ir_update:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      t.st == bst_pkg::ST_UPD_IR |=> t.ir == $past(t.ir_sh))
      else $error("instruction not updated");

   chk_tap_reset:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      TMS [*5] |=> t.st == bst_pkg::ST_RESET)
      else $error("five TMS highs did not reset");

   chk_tdo_float:
   assert property (@(posedge TCK) disable iff (!t.rs2)
      !in_shift |-> !TDO_OE)
      else $error("TDO driven outside shift");

   chk_cfg_ack:
   assert property (@(posedge REF_CLK) disable iff (!NRST)
      r.pend && fbus.in_ready |=> !r.pend && r.ack != $past(r.ack))
      else $error("config byte not handed over");

   chk_cfg_pins:
   assert property (@(posedge REF_CLK) disable iff (!NRST)
      r.c2 |=> PIN_OUT == $past(CORE_OUT))
      else $error("pins tested while configuring");

endmodule // bst_tap

// ---- verif/bst_ctl.sv ----
// Scan controller model: drives tck, tms and tdi, and samples tdo.
// Assumes tdo arrives through a pulled-up wire.
`timescale 1ns/1ps
module bst_ctl (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic [1099:0] rx;

   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // ----------------------------------------
   // One link cycle; clock stands low between frames
   // ----------------------------------------
   task automatic tick(input logic m, input logic d, output logic q);
      #20 tms = m;
      tdi = d;
      #20 tck = 1'b1;
      q = tdo;
      #40 tck = 1'b0;
   endtask

   task automatic reset_tap();
      logic q;
      repeat (5) tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask

   // ----------------------------------------
   // Idle to shift, n bits LSB first, back to idle
   // ----------------------------------------
   task automatic scan(input logic ir, input logic [1099:0] tx, input int n);
      logic q;
      tick(1'b1, 1'b1, q);
      if (ir) tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
      tick(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, tx[i], q);
         rx[i] = q;
      end
      tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask
endmodule // bst_ctl

// ---- verif/tb_boundary_scan_test_port.sv ----
// Self-checking bench of the boundary-scan port with a controller model.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ps
module tb_boundary_scan_test_port;
   localparam int          L    = bst_pkg::BSR_LEN_V2;
   localparam logic [3:0]  VER  = 4'h9;       // Arbitrary value
   localparam logic [15:0] PART = 16'h1E7D;   // Arbitrary value
   localparam logic [10:0] MFR  = 11'h35A;    // Arbitrary value
   localparam logic [24:0] FIX  = 25'h0ABCDEF; // Arbitrary value
   localparam logic [31:0] ID_W = {VER, PART, MFR, 1'b1};
   typedef struct {
      logic [9:0]    op;
      int            len;
      logic [1099:0] cap;
   } bst_row_t;

   logic          ref_clk, nrst, tck, tms, tdi, tdo, tdo_oe;
   logic          configuring, cfg_valid, cfg_ready;
   logic [L-1:0]  pin_in, core_out, pin_out, pat;
   logic [6:0]    user_sig;
   logic [7:0]    cfg_data;
   logic [1099:0] exp_v;
   bst_row_t      rows [5];
   int            failures, n_checks, nb;
   // The TDO link pin carries a weak pull-up
   wire           tdo_w = tdo_oe ? tdo : 1'b1;

   bst_tap #(.BSR_LEN(L), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR),
      .USER_FIXED(FIX)) dut_u (.REF_CLK(ref_clk), .NRST(nrst), .TCK(tck),
      .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .PIN_IN(pin_in),
      .CORE_OUT(core_out), .PIN_OUT(pin_out), .USER_SIG(user_sig),
      .CONFIGURING(configuring), .CFG_DATA(cfg_data),
      .CFG_VALID(cfg_valid), .CFG_READY(cfg_ready));
   bst_ctl ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

   // ----------------------------------------
   // Clock, compare and verdict
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [1099:0] e,
                      input logic [1099:0] g);
      n_checks++;
      if (e !== g) begin
         failures++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic test_done();
      if (failures == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #2000000;
      failures++;
      test_done();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      n_checks = 0;
      nrst = 1'b0;
      cfg_ready = 1'b0;
      user_sig = 7'h5B;
      for (int i = 0; i < L; i++) begin
         pin_in[i] = (i % 3) == 0;
         core_out[i] = (i % 5) == 1;
         pat[i] = (i % 7) == 2;
      end
      // TCK side resets only while its clock runs
      fork
         repeat (8) @(posedge ref_clk);
         ctl_u.reset_tap();
      join
      @(posedge ref_clk) nrst <= 1'b1;
      ctl_u.reset_tap();
      chk("tdo_oe", 1'b0, tdo_oe);
      chk("configuring", 1'b0, configuring);
      ctl_u.scan(1'b0, 1100'h0, 32);
      chk("id_after_reset", ID_W, ctl_u.rx[31:0]);
      rows[0] = '{bst_pkg::OP_DEVICE_IDENTITY_REGISTER, 32, ID_W};
      rows[1] = '{bst_pkg::OP_USER_SIGNATURE_REGISTER, 32, {FIX, user_sig}};
      rows[2] = '{bst_pkg::OP_BYPASS, 1, 1100'h0};
      rows[3] = '{10'h155, 1, 1100'h0};
      rows[4] = '{bst_pkg::OP_SAMPLE, L, pin_in};
      // Marker byte trails the register by exactly its length
      for (int r = 0; r < 5; r++) begin
         ctl_u.scan(1'b1, rows[r].op, 10);
         chk("ir_capture", bst_pkg::IR_CAPT, ctl_u.rx[9:0]);
         ctl_u.scan(1'b0, 1100'hA5, rows[r].len + 8);
         exp_v = (1100'hA5 << rows[r].len) | rows[r].cap;
         exp_v = exp_v ^ (ctl_u.rx & ~((1100'h1 << (rows[r].len + 8)) - 1));
         chk("dr_out", exp_v, ctl_u.rx);
      end
      chk("pin_out_normal", core_out, pin_out);
      ctl_u.scan(1'b0, pat, L);
      ctl_u.scan(1'b1, bst_pkg::OP_EXTEST, 10);
      for (int k = 0; k < 20 && pin_out !== pat; k++) @(posedge ref_clk);
      chk("pin_out_extest", pat, pin_out);
      ctl_u.scan(1'b0, 1100'h0, L);
      chk("extest_capture", pin_in, ctl_u.rx[L-1:0]);
      ctl_u.scan(1'b1, bst_pkg::OP_CFG_LOAD, 10);
      repeat (8) @(posedge ref_clk);
      chk("configuring", 1'b1, configuring);
      chk("pin_out_cfg", core_out, pin_out);
      // Consumer stalls until the buffer refuses
      for (int b = 0; b < 20; b++) ctl_u.scan(1'b0, 8'h30 + b, 8);
      @(posedge ref_clk) cfg_ready <= 1'b1;
      nb = 0;
      repeat (60) begin
         @(posedge ref_clk);
         if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
            if (nb < 18) chk("cfg_data", 8'h30 + nb, cfg_data);
            nb++;
         end
      end
      // Output register, sixteen buffered, one pending; the rest dropped
      chk("cfg_count", 18, nb);
      chk("cfg_valid_end", 1'b0, cfg_valid);
      ctl_u.scan(1'b1, bst_pkg::OP_BYPASS, 10);
      repeat (8) @(posedge ref_clk);
      chk("configuring", 1'b0, configuring);
      test_done();
   end
endmodule // tb_boundary_scan_test_port
